// ### src/spc_pkg.sv
package spc_pkg;
	// register bus geometry: bit 8 of the address picks the logical device
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int EV_W = 4;

	// first port (device select 0) indexes
	localparam logic [8:0] A_P1_ACT = 9'h030;
	localparam logic [8:0] A_P1_BAH = 9'h060;
	localparam logic [8:0] A_P1_BAL = 9'h061;
	localparam logic [8:0] A_P1_IRQ = 9'h070;
	localparam logic [8:0] A_P1_ITYPE = 9'h071;
	localparam logic [8:0] A_P1_DMA_A = 9'h074;
	localparam logic [8:0] A_P1_DMA_B = 9'h075;
	localparam logic [8:0] A_P1_CFG = 9'h0f0;
	// second port (device select 1) indexes
	localparam logic [8:0] A_P2_CFG = 9'h1f0;
	localparam logic [8:0] A_EV_STAT = 9'h1f8;
	localparam logic [8:0] A_EV_MASK = 9'h1f9;

	// reset values
	localparam logic [7:0] RST_ACT = 8'h00;
	localparam logic [7:0] RST_BAH = 8'h03;
	localparam logic [7:0] RST_BAL = 8'hf8;
	localparam logic [7:0] RST_IRQ = 8'h04;
	localparam logic [7:0] RST_ITYPE = 8'h03;
	localparam logic [7:0] DMA_NONE = 8'h04;
	localparam logic [7:0] RST_CFG = 8'h02;

	// writable bits of the mixed registers
	localparam logic [7:0] WM_BAH = 8'h07;
	localparam logic [7:0] WM_BAL = 8'hf8;
	localparam logic [7:0] WM_ITYPE = 8'h02;
	localparam logic [7:0] WM_CFG = 8'hc3;

	// device configuration and activation field positions
	localparam int CFG_BANK = 7;
	localparam int CFG_FLOAT = 6;
	localparam int CFG_BUSY = 2;
	localparam int CFG_PWR = 1;
	localparam int CFG_IDLEFLT = 0;
	localparam int ACT_BIT = 0;

	// event status bit positions
	localparam int EV_P1_RING = 0;
	localparam int EV_P2_RING = 1;
	localparam int EV_P1_DONE = 2;
	localparam int EV_P2_DONE = 3;

	// per-port controls handed to the serial port logic
	typedef struct packed {
		logic clk_en;
		logic out_default;
		logic pins_float;
		logic in_hold_high;
		logic runtime_ok;
		logic bank_ok;
	} spc_port_ctl_t;

	// register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic we;
		logic re;
	} spc_bus_req_t;

	// whole state of the register bank
	typedef struct packed {
		logic [7:0] p1_act;
		logic [7:0] p1_bah;
		logic [7:0] p1_bal;
		logic [7:0] p1_irq;
		logic [7:0] p1_itype;
		logic [7:0] p1_cfg;
		logic [7:0] p2_cfg;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [7:0] rdata;
		logic [1:0] ring_prev;
		logic [1:0] busy_prev;
	} spc_state_t;

	localparam spc_state_t RST_STATE = '{p1_act: RST_ACT, p1_bah: RST_BAH,
		p1_bal: RST_BAL, p1_irq: RST_IRQ, p1_itype: RST_ITYPE,
		p1_cfg: RST_CFG, p2_cfg: RST_CFG, status: 4'h0, mask: 4'h0,
		rdata: 8'h00, ring_prev: 2'h0, busy_prev: 2'h0};
endpackage

// ### src/spc_regs.sv
`timescale 1ns/10ps
`default_nettype none

module spc_regs (
	input wire logic clk,
	input wire logic arst_n,
	input wire spc_pkg::spc_bus_req_t bus,
	output logic [7:0] rdata,
	output logic irq,
	input wire logic p1_busy,
	input wire logic p2_busy,
	input wire logic p1_ring,
	input wire logic p2_ring,
	input wire logic p2_active,
	output spc_pkg::spc_port_ctl_t p1_ctl,
	output spc_pkg::spc_port_ctl_t p2_ctl,
	output logic [15:0] p1_base,
	output logic [7:0] p1_irq_sel,
	output logic [7:0] p1_irq_type
);

	////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state and derived signals
	spc_pkg::spc_state_t st_reg;
	spc_pkg::spc_state_t st_next;
	logic p1_active;
	logic [1:0] busy_in;
	logic [1:0] ring_in;
	logic [1:0] active_in;
	logic [15:0] cfg_pair;
	spc_pkg::spc_port_ctl_t ctl [2];

	// merge masked write data into a register
	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] wd, input logic [7:0] wm);
		merge = (old & ~wm) | (wd & wm);
	endfunction

	assign p1_active = st_reg.p1_act[spc_pkg::ACT_BIT];
	assign busy_in = {p2_busy, p1_busy};
	assign ring_in = {p2_ring, p1_ring};
	assign active_in = {p2_active, p1_active};
	assign cfg_pair = {st_reg.p2_cfg, st_reg.p1_cfg};

	// per-port pin, clock and access controls
	for (genvar i = 0; i < 2; i++)
	begin : g_port
		logic [7:0] cfg;
		assign cfg = cfg_pair[8*i +: 8];
		// clock runs only while active in normal power
		assign ctl[i].clk_en = active_in[i] & cfg[spc_pkg::CFG_PWR];
		assign ctl[i].out_default = active_in[i] & ~cfg[spc_pkg::CFG_PWR];
		// forced float wins over activation; idle float only when inactive
		assign ctl[i].pins_float = cfg[spc_pkg::CFG_FLOAT] |
			(cfg[spc_pkg::CFG_IDLEFLT] & ~active_in[i]);
		assign ctl[i].in_hold_high = cfg[spc_pkg::CFG_FLOAT];
		// low power keeps runtime access, deactivation removes it
		assign ctl[i].runtime_ok = active_in[i];
		assign ctl[i].bank_ok = active_in[i] & cfg[spc_pkg::CFG_BANK];
	end

	assign p1_ctl = ctl[0];
	assign p2_ctl = ctl[1];

	////////////////////////////////////////////////////////////////////
	// next state: register writes, reads, events
	always_comb
	begin
		logic [spc_pkg::EV_W-1:0] ev;
		logic rd_stat;
		ev = '0;
		rd_stat = bus.re && (bus.addr == spc_pkg::A_EV_STAT);
		st_next = st_reg;
		st_next.ring_prev = ring_in;
		st_next.busy_prev = busy_in;
		// ring edges count even with the port clock stopped
		ev[spc_pkg::EV_P1_RING] = ring_in[0] & ~st_reg.ring_prev[0];
		ev[spc_pkg::EV_P2_RING] = ring_in[1] & ~st_reg.ring_prev[1];
		ev[spc_pkg::EV_P1_DONE] = ~busy_in[0] & st_reg.busy_prev[0];
		ev[spc_pkg::EV_P2_DONE] = ~busy_in[1] & st_reg.busy_prev[1];
		// read clears, a same-cycle event still sets
		st_next.status = (rd_stat ? '0 : st_reg.status) | ev;
		if (bus.we)
		begin
			case (bus.addr)
				spc_pkg::A_P1_ACT: st_next.p1_act = bus.wdata;
				spc_pkg::A_P1_BAH:
					st_next.p1_bah = merge(st_reg.p1_bah, bus.wdata,
						spc_pkg::WM_BAH);
				spc_pkg::A_P1_BAL:
					st_next.p1_bal = merge(st_reg.p1_bal, bus.wdata,
						spc_pkg::WM_BAL);
				spc_pkg::A_P1_IRQ: st_next.p1_irq = bus.wdata;
				spc_pkg::A_P1_ITYPE:
					st_next.p1_itype = merge(st_reg.p1_itype, bus.wdata,
						spc_pkg::WM_ITYPE);
				spc_pkg::A_P1_CFG:
					st_next.p1_cfg = merge(st_reg.p1_cfg, bus.wdata,
						spc_pkg::WM_CFG);
				spc_pkg::A_P2_CFG:
					st_next.p2_cfg = merge(st_reg.p2_cfg, bus.wdata,
						spc_pkg::WM_CFG);
				spc_pkg::A_EV_MASK:
					st_next.mask = bus.wdata[spc_pkg::EV_W-1:0];
				default: st_next.rdata = st_reg.rdata;
			endcase
		end
		// read data stands in the cycle after the strobe only
		st_next.rdata = 8'h00;
		if (bus.re)
		begin
			case (bus.addr)
				spc_pkg::A_P1_ACT: st_next.rdata = st_reg.p1_act;
				spc_pkg::A_P1_BAH: st_next.rdata = st_reg.p1_bah;
				spc_pkg::A_P1_BAL: st_next.rdata = st_reg.p1_bal;
				spc_pkg::A_P1_IRQ: st_next.rdata = st_reg.p1_irq;
				spc_pkg::A_P1_ITYPE: st_next.rdata = st_reg.p1_itype;
				spc_pkg::A_P1_DMA_A: st_next.rdata = spc_pkg::DMA_NONE;
				spc_pkg::A_P1_DMA_B: st_next.rdata = spc_pkg::DMA_NONE;
				spc_pkg::A_P1_CFG:
				begin
					st_next.rdata = st_reg.p1_cfg;
					st_next.rdata[spc_pkg::CFG_BUSY] = busy_in[0];
				end
				spc_pkg::A_P2_CFG:
				begin
					st_next.rdata = st_reg.p2_cfg;
					st_next.rdata[spc_pkg::CFG_BUSY] = busy_in[1];
				end
				spc_pkg::A_EV_STAT: st_next.rdata = {4'h0, st_reg.status};
				spc_pkg::A_EV_MASK: st_next.rdata = {4'h0, st_reg.mask};
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	// state register, loaded with reset values
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= spc_pkg::RST_STATE;
		else
			st_reg <= st_next;
	end

	// outputs
	assign rdata = st_reg.rdata;
	assign irq = |(st_reg.status & st_reg.mask);
	assign p1_base = {st_reg.p1_bah, st_reg.p1_bal};
	assign p1_irq_sel = st_reg.p1_irq;
	assign p1_irq_type = st_reg.p1_itype;

	////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_wr(logic [8:0] a);
		bus.we && bus.addr == a;
	endsequence

	sequence s_rd(logic [8:0] a);
		bus.re && bus.addr == a;
	endsequence

	sequence s_port1_stays_active;
		p1_active ##1 p1_active;
	endsequence

	a_bank_gate: assert property (
		s_wr(spc_pkg::A_P1_CFG) and !bus.wdata[7] |=> !p1_ctl.bank_ok)
		else $error("bank access left open with enable clear");

	a_forced_float: assert property (
		s_wr(spc_pkg::A_P1_CFG) and bus.wdata[6]
		|=> p1_ctl.pins_float && p1_ctl.in_hold_high)
		else $error("forced float did not float the port");

	a_busy_shown: assert property (
		s_rd(spc_pkg::A_P1_CFG) |=> rdata[2] == $past(p1_busy))
		else $error("busy bit does not follow transfer state");

	a_low_power: assert property (
		(s_wr(spc_pkg::A_P1_CFG) and !bus.wdata[1]) ##0 s_port1_stays_active
		|-> !p1_ctl.clk_en && p1_ctl.out_default)
		else $error("low power did not stop the clock");

	a_ring_wake: assert property (
		!p1_ctl.clk_en && p1_ring && !$past(p1_ring)
		|=> st_reg.status[spc_pkg::EV_P1_RING])
		else $error("ring edge lost in low power");

	a_normal_run: assert property (
		(s_wr(spc_pkg::A_P1_CFG) and bus.wdata[1]) ##0 s_port1_stays_active
		|-> p1_ctl.clk_en && !p1_ctl.out_default)
		else $error("normal power did not run the clock");

	a_act_block: assert property (
		s_wr(spc_pkg::A_P1_ACT) and !bus.wdata[0]
		|=> !p1_ctl.runtime_ok && !p1_ctl.bank_ok)
		else $error("runtime access open after deactivation");

	a_idle_float: assert property (
		s_wr(spc_pkg::A_P1_ACT)
		and (st_reg.p1_cfg[0] && !bus.wdata[0])
		|=> p1_ctl.pins_float)
		else $error("inactive port pins not floated");

	a_reset_cfg: assert property (
		$rose(rst_n) |-> st_reg.p2_cfg == 8'h02 && st_reg.p1_cfg == 8'h02)
		else $error("device configuration reset value wrong");

	a_base_high: assert property (
		s_rd(spc_pkg::A_P1_BAH) |=> rdata[7:3] == 5'h00)
		else $error("base high read-only bits not zero");

	a_base_low: assert property (
		s_rd(spc_pkg::A_P1_BAL) |=> rdata[2:0] == 3'h0)
		else $error("base low read-only bits not zero");

	a_irq_sel: assert property (
		s_wr(spc_pkg::A_P1_IRQ) |=> p1_irq_sel == $past(bus.wdata))
		else $error("interrupt select did not store");

	a_irq_read: assert property (
		s_rd(spc_pkg::A_P1_IRQ) |=> rdata == $past(p1_irq_sel))
		else $error("interrupt select read back wrong");

	a_itype_ro: assert property (
		s_rd(spc_pkg::A_P1_ITYPE) |=> (rdata & 8'hfd) == 8'h01)
		else $error("interrupt type read-only bits changed");

	a_no_dma: assert property (
		s_rd(spc_pkg::A_P1_DMA_A) or s_rd(spc_pkg::A_P1_DMA_B)
		|=> rdata == 8'h04)
		else $error("dma report not fixed");

	a_rsvd_zero: assert property (
		s_rd(spc_pkg::A_P2_CFG) |=> rdata[5:3] == 3'h0)
		else $error("reserved configuration bits not zero");

	// second port controls follow its own configuration register
	a_p2_bank_gate: assert property (
		s_wr(spc_pkg::A_P2_CFG) and !bus.wdata[7]
		|=> !p2_ctl.bank_ok)
		else $error("second port bank access open");

	a_p2_float: assert property (
		s_wr(spc_pkg::A_P2_CFG) and bus.wdata[6]
		|=> p2_ctl.pins_float && p2_ctl.in_hold_high)
		else $error("forced float did not float the second port");

	a_p2_busy: assert property (
		s_rd(spc_pkg::A_P2_CFG) |=> rdata[2] == $past(p2_busy))
		else $error("second port busy bit wrong");

	a_p2_inactive: assert property (
		$fell(p2_active) |-> !p2_ctl.runtime_ok && !p2_ctl.clk_en)
		else $error("second port still open after deactivation");

	a_p2_idle_float: assert property (
		!p2_active && st_reg.p2_cfg[0] |-> p2_ctl.pins_float)
		else $error("inactive second port pins not floated");

	// ring edge seen on the first port input
	sequence s_ring_rise;
		p1_ring && !$past(p1_ring);
	endsequence

	a_ring_irq: assert property (
		s_ring_rise and (st_reg.mask[spc_pkg::EV_P1_RING] && !bus.we)
		|=> irq)
		else $error("unmasked ring edge raised no interrupt");

	a_status_sticky: assert property (
		st_reg.status[spc_pkg::EV_P1_RING] && !bus.re
		|=> st_reg.status[spc_pkg::EV_P1_RING])
		else $error("ring status lost without a status read");

	a_status_clear: assert property (
		s_rd(spc_pkg::A_EV_STAT) and (!p1_ring && !p2_ring)
		|=> st_reg.status[1:0] == 2'h0)
		else $error("status read did not clear ring bits");

	a_base_high_wr: assert property (
		s_wr(spc_pkg::A_P1_BAH)
		|=> p1_base[15:8] == {5'h00, $past(bus.wdata[2:0])})
		else $error("base high write not masked");

	a_base_low_wr: assert property (
		s_wr(spc_pkg::A_P1_BAL)
		|=> p1_base[7:0] == {$past(bus.wdata[7:3]), 3'h0})
		else $error("base low write not masked");

	a_itype_wr: assert property (
		s_wr(spc_pkg::A_P1_ITYPE)
		|=> p1_irq_type == {6'h00, $past(bus.wdata[1]), 1'b1})
		else $error("interrupt type write not masked");

	a_rsvd_keep: assert property (
		s_wr(spc_pkg::A_P1_CFG) or s_wr(spc_pkg::A_P2_CFG)
		|=> st_reg.p1_cfg[5:2] == 4'h0
			&& st_reg.p2_cfg[5:2] == 4'h0)
		else $error("reserved configuration bits took a write");

	a_reset_port: assert property (
		$rose(rst_n) |-> p1_irq_sel == 8'h04 && p1_irq_type == 8'h03
			&& p1_base == 16'h03f8)
		else $error("port register reset values wrong");

endmodule

`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic clk;
	logic arst_n;
	spc_pkg::spc_bus_req_t bus;
	logic [7:0] rdata;
	logic irq;
	logic p1_busy, p2_busy, p1_ring, p2_ring, p2_active;
	spc_pkg::spc_port_ctl_t p1_ctl, p2_ctl;
	logic [15:0] p1_base;
	logic [7:0] p1_irq_sel, p1_irq_type;
	int err_count;
	int checked;
	logic [7:0] cfg_tab [8];
	logic act_tab [8];

	////////////////////////////////////////////////////////////////////////
	// device under test
	spc_regs uut (
		.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .irq(irq),
		.p1_busy(p1_busy), .p2_busy(p2_busy), .p1_ring(p1_ring),
		.p2_ring(p2_ring), .p2_active(p2_active), .p1_ctl(p1_ctl),
		.p2_ctl(p2_ctl), .p1_base(p1_base), .p1_irq_sel(p1_irq_sel),
		.p1_irq_type(p1_irq_type)
	);

	// free running 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// compare, count and report
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// print counts and verdict, then stop
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.we <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.we <= 1'b0;
	endtask

	// one-cycle read strobe, data checked in the following cycle
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk);
		bus.re <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.re <= 1'b0;
		@(negedge clk);
		chk({8'h00, rdata}, {8'h00, e});
	endtask

	// write then read back through the mask of writable bits
	task automatic wrd(input logic [8:0] a, input logic [7:0] d,
		input logic [7:0] e);
		wr(a, d);
		rd(a, e);
	endtask

	// bounded wait for the interrupt level
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
		chk({15'h0, irq}, 16'h0001);
		if (n >= 8)
			wrap_up();
	endtask

	// expected port controls worked out from activation and config bits
	function automatic logic [7:0] exp_ctl(input logic a, input logic [7:0] c);
		return {2'h0, a & c[1], a & ~c[1], c[6] | (c[0] & ~a), c[6], a, a & c[7]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		arst_n = 1'b0;
		bus = '0;
		{p1_busy, p2_busy, p1_ring, p2_ring, p2_active} = 5'h00;
		err_count = 0;
		checked = 0;
		cfg_tab = '{8'h02, 8'h82, 8'h80, 8'h01, 8'h00, 8'h40, 8'hc3, 8'h01};
		act_tab = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// reset values and fixed reports
		rd(spc_pkg::A_P1_ACT, 8'h00);
		rd(spc_pkg::A_P1_BAH, 8'h03);
		rd(spc_pkg::A_P1_BAL, 8'hf8);
		rd(spc_pkg::A_P1_IRQ, 8'h04);
		rd(spc_pkg::A_P1_ITYPE, 8'h03);
		rd(spc_pkg::A_P1_CFG, 8'h02);
		rd(spc_pkg::A_P2_CFG, 8'h02);
		rd(9'h0a5, 8'h00);
		chk(p1_base, 16'h03f8);
		// writable and read-only bits
		wrd(spc_pkg::A_P1_BAH, 8'hff, 8'h07);
		wrd(spc_pkg::A_P1_BAL, 8'h07, 8'h00);
		chk(p1_base, 16'h0700);
		wrd(spc_pkg::A_P1_BAL, 8'hff, 8'hf8);
		wrd(spc_pkg::A_P1_IRQ, 8'ha5, 8'ha5);
		chk({8'h00, p1_irq_sel}, 16'h00a5);
		wrd(spc_pkg::A_P1_ITYPE, 8'h00, 8'h01);
		wrd(spc_pkg::A_P1_ITYPE, 8'hfe, 8'h03);
		chk({8'h00, p1_irq_type}, 16'h0003);
		wrd(spc_pkg::A_P1_DMA_A, 8'h00, 8'h04);
		wrd(spc_pkg::A_P1_DMA_B, 8'hff, 8'h04);
		wrd(spc_pkg::A_P1_CFG, 8'hff, 8'hc3);
		wrd(spc_pkg::A_P2_CFG, 8'h3c, 8'h00);
		wr(9'h0a5, 8'h5a);
		rd(9'h0a5, 8'h00);
		// live busy bit, then busy falls raise masked events
		@(posedge clk);
		{p1_busy, p2_busy} <= 2'b11;
		rd(spc_pkg::A_P1_CFG, 8'hc7);
		rd(spc_pkg::A_P2_CFG, 8'h04);
		@(posedge clk);
		{p1_busy, p2_busy} <= 2'b00;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
		rd(spc_pkg::A_EV_STAT, 8'h0c);
		rd(spc_pkg::A_EV_STAT, 8'h00);
		// port controls for both ports over a table of settings
		for (int i = 0; i < 8; i++)
		begin
			wr(spc_pkg::A_P1_ACT, {7'h00, act_tab[i]});
			wr(spc_pkg::A_P1_CFG, cfg_tab[i]);
			p2_active <= act_tab[i];
			wr(spc_pkg::A_P2_CFG, cfg_tab[i]);
			@(negedge clk);
			chk({10'h0, p1_ctl}, {8'h00, exp_ctl(act_tab[i], cfg_tab[i])});
			chk({10'h0, p2_ctl}, {8'h00, exp_ctl(act_tab[i], cfg_tab[i])});
		end
		rd(spc_pkg::A_P1_IRQ, 8'ha5);
		// ring event in low power raises the interrupt
		wr(spc_pkg::A_P1_CFG, 8'h00);
		wrd(spc_pkg::A_EV_MASK, 8'h01, 8'h01);
		@(posedge clk);
		p1_ring <= 1'b1;
		wait_irq();
		rd(spc_pkg::A_EV_STAT, 8'h01);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
		// masked ring event sets status without interrupt
		@(posedge clk);
		p2_ring <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
		rd(spc_pkg::A_EV_STAT, 8'h02);
		wrap_up();
	end
endmodule

`default_nettype wire
